// ===== rtl/gocd_top.sv
// gocd_top: divider two with its registers, plus routing and power-down of groups one and two
// assumes: register strobes come from the serial control core on ref_clk; clock and sync pins are async
//
// How it works
// - group one power-down bit set parks its three driver pairs safely off.
// - direct bit clear drives group one outputs from its own channel divider.
// - direct bit set with source 10 routes the oscillator straight to group one.
// - direct bit set with source 00 routes the external clock straight to group one.
// - direct bit set with source 01 leaves group one routing unchanged.
// - correction disable clear applies duty-cycle correction; set leaves it off.
// - low time is the low-count field plus one input cycles, reset value one.
// - high time is the high-count field plus one input cycles, reset value one.
// - bypass bit stops the divider and passes its input straight through.
// - ignore-sync clear obeys the chip sync; set disregards it.
// - forcing holds output low, or at the start-high level when force is one.
// - while bypassed the force bit has no effect on the output.
// - start-high bit picks the divider's starting level, low by default.
// - four-bit phase offset delays the divider's start, reset value zero.
// - power-down sits at bit two of channel register; bits above unused.
// - group two power-down bit set parks its three driver pairs safely off.
module gocd_top (
	input  wire logic                 ref_clk,
	input  wire logic                 rstn,
	input  gocd_pkg::gocd_reg_req_s   reg_req,
	output logic [gocd_pkg::DATA_W-1:0] reg_rdata,
	output logic                      reg_rvalid,
	input  wire logic [1:0]           src_sel,
	input  wire logic                 osc_clk_pin,
	input  wire logic                 ext_clk_pin,
	input  wire logic                 sync_n_pin,
	input  wire logic                 group_one_div_lvl,
	output gocd_pkg::gocd_drv_s       group_one_driver,
	output gocd_pkg::gocd_drv_s       group_two_driver
);
	import gocd_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0]  grp_one_ctrl;
		logic [DATA_W-1:0]  div_counts;
		logic [DATA_W-1:0]  div_ctrl;
		logic [DATA_W-1:0]  grp_two_ctrl;
		logic [PIN_NUM-1:0] sync1;
		logic [PIN_NUM-1:0] sync2;
		logic [PIN_NUM-1:0] sync3;
		logic               div_out;
		logic [DATA_W-1:0]  rdata;
		logic               rvalid;
		logic               hp_out;
		logic               hp_run;
		logic [LEN_W-1:0]   hp_ticks;
		gocd_div_cfg_s      hp_cfg;
		logic               hp_dirty;
	} gocd_top_reg_s;

	gocd_top_reg_s           r_ff;
	gocd_top_reg_s           nxt_r;
	gocd_div_cfg_s           cfg;
	logic                    in_lvl;
	logic                    in_prev;
	logic                    tick;
	logic                    sync_active;
	logic                    bypass;
	logic                    ignore_sync;
	logic                    force_bit;
	logic                    dv_restart;
	logic                    dv_lvl;
	logic                    dv_run;
	logic [DATA_W-1:0]       status;
	logic                    hp_chg;
	logic [LEN_W-1:0]        hp_total;
	logic [NUM_GROUPS-1:0]   grp_pd;
	logic [NUM_GROUPS-1:0]   grp_direct;
	logic [NUM_GROUPS-1:0]   grp_div_lvl;
	gocd_drv_s               grp_drv [NUM_GROUPS];

	// decoded configuration of divider two
	always_comb begin
		cfg.low_cnt    = r_ff.div_counts[LOW_LSB +: CNT_W];
		cfg.high_cnt   = r_ff.div_counts[HIGH_LSB +: CNT_W];
		cfg.phase      = r_ff.div_ctrl[PHASE_LSB +: CNT_W];
		cfg.start_high = r_ff.div_ctrl[BIT_START_HIGH];
		cfg.dcc_en     = !r_ff.grp_two_ctrl[BIT_DCC_DIS];
		bypass         = r_ff.div_ctrl[BIT_BYPASS];
		ignore_sync    = r_ff.div_ctrl[BIT_IGN_SYNC];
		force_bit      = r_ff.div_ctrl[BIT_FORCE];
	end

	// divider input: synchronised pin level, rising edge gives one tick per input cycle
	always_comb begin
		in_lvl      = (src_sel == SRC_EXT) ? r_ff.sync2[PIN_EXT] : r_ff.sync2[PIN_OSC];
		in_prev     = (src_sel == SRC_EXT) ? r_ff.sync3[PIN_EXT] : r_ff.sync3[PIN_OSC];
		tick        = in_lvl && !in_prev;
		sync_active = !r_ff.sync2[PIN_SYNC];
		// bypass powers the counter down; ignore-sync and an active sync also park it
		dv_restart  = bypass || ignore_sync || sync_active;
	end

	gocd_divider u_div (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.tick    (tick),
		.restart (dv_restart),
		.cfg     (cfg),
		.out_lvl (dv_lvl),
		.running (dv_run)
	);

	// status word: own state for software to read back
	always_comb begin
		status              = '0;
		status[ST_DIV_OUT]  = r_ff.div_out;
		status[ST_RUN]      = dv_run;
		status[ST_SYNC]     = sync_active;
	end

	// helper for the period checks: input ticks since the last output change
	always_comb begin
		hp_chg   = (dv_lvl != r_ff.hp_out) || (dv_run && !r_ff.hp_run);
		hp_total = LEN_W'(cfg.low_cnt) + LEN_W'(cfg.high_cnt) + CYC_ONE + CYC_ONE;
	end

	// next state: synchronisers, register writes, reads and the divider output mux
	always_comb begin
		nxt_r       = r_ff;
		nxt_r.sync1 = {sync_n_pin, ext_clk_pin, osc_clk_pin};
		nxt_r.sync2 = r_ff.sync1;
		nxt_r.sync3 = r_ff.sync2;
		if (reg_req.wr) begin
			case (reg_req.addr)
				ADDR_GRP_ONE_CTRL: nxt_r.grp_one_ctrl = reg_req.wdata & CHAN_USED_MASK;
				ADDR_DIV_COUNTS:   nxt_r.div_counts   = reg_req.wdata;
				ADDR_DIV_CTRL:     nxt_r.div_ctrl     = reg_req.wdata;
				ADDR_GRP_TWO_CTRL: nxt_r.grp_two_ctrl = reg_req.wdata & CHAN_USED_MASK;
				default:           nxt_r.rvalid       = r_ff.rvalid;
			endcase
		end
		nxt_r.rvalid = reg_req.rd;
		if (reg_req.rd) begin
			case (reg_req.addr)
				ADDR_GRP_ONE_CTRL: nxt_r.rdata = r_ff.grp_one_ctrl;
				ADDR_DIV_COUNTS:   nxt_r.rdata = r_ff.div_counts;
				ADDR_DIV_CTRL:     nxt_r.rdata = r_ff.div_ctrl;
				ADDR_GRP_TWO_CTRL: nxt_r.rdata = r_ff.grp_two_ctrl;
				ADDR_STATUS:       nxt_r.rdata = status;
				default:           nxt_r.rdata = '0;
			endcase
		end
		// bypass outranks force, so the input level reaches the output unaltered
		if (bypass) begin
			nxt_r.div_out = in_lvl;
		end else if (ignore_sync) begin
			nxt_r.div_out = force_bit ? cfg.start_high : 1'b0;
		end else begin
			nxt_r.div_out = dv_lvl;
		end
		nxt_r.hp_out   = dv_lvl;
		nxt_r.hp_run   = dv_run;
		nxt_r.hp_ticks = hp_chg ? LEN_W'(tick) : r_ff.hp_ticks + LEN_W'(tick);
		// a config write inside a half period leaves that half's length undefined, so the checks skip it
		nxt_r.hp_cfg   = cfg;
		nxt_r.hp_dirty = (cfg != r_ff.hp_cfg) || (!hp_chg && r_ff.hp_dirty);
	end

	// one register for all state; sync lane resets low so power-up acts as a sync
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			r_ff              <= '0;
			r_ff.grp_one_ctrl <= RST_CHAN_CTRL;
			r_ff.div_counts   <= RST_DIV_COUNTS;
			r_ff.div_ctrl     <= RST_DIV_CTRL;
			r_ff.grp_two_ctrl <= RST_CHAN_CTRL;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// per-group controls: group one takes its divider from outside
	always_comb begin
		grp_pd[0]      = r_ff.grp_one_ctrl[BIT_PD];
		grp_pd[1]      = r_ff.grp_two_ctrl[BIT_PD];
		grp_direct[0]  = r_ff.grp_one_ctrl[BIT_DIRECT];
		grp_direct[1]  = r_ff.grp_two_ctrl[BIT_DIRECT];
		grp_div_lvl[0] = group_one_div_lvl;
		grp_div_lvl[1] = r_ff.div_out;
	end

	// one router per group
	for (genvar g = 0; g < NUM_GROUPS; g++) begin : gen_grp
		gocd_route u_route (
			.ref_clk (ref_clk),
			.rstn    (rstn),
			.div_lvl (grp_div_lvl[g]),
			.osc_lvl (r_ff.sync2[PIN_OSC]),
			.ext_lvl (r_ff.sync2[PIN_EXT]),
			.src_sel (src_sel),
			.direct  (grp_direct[g]),
			.pd      (grp_pd[g]),
			.drv     (grp_drv[g])
		);
	end

	assign group_one_driver = grp_drv[0];
	assign group_two_driver = grp_drv[1];
	assign reg_rdata        = r_ff.rdata;
	assign reg_rvalid       = r_ff.rvalid;

	// checks on routing, divider timing and register layout
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	pd_one_a: assert property (grp_pd[0] |=> !group_one_driver.en && group_one_driver.lvl == '0)
		else $error("group one not parked while powered down");

	pd_two_a: assert property (grp_pd[1] |=> !group_two_driver.en && group_two_driver.lvl == '0)
		else $error("group two not parked while powered down");

	route_div_a: assert property (!grp_pd[0] && !grp_direct[0]
		|=> group_one_driver.en && group_one_driver.lvl == {DRV_PER_GRP{$past(group_one_div_lvl)}})
		else $error("group one not fed by its divider");

	route_osc_a: assert property (!grp_pd[0] && grp_direct[0] && src_sel == SRC_OSC
		|=> group_one_driver.lvl == {DRV_PER_GRP{$past(r_ff.sync2[PIN_OSC])}})
		else $error("group one not fed by oscillator");

	route_ext_a: assert property (!grp_pd[0] && grp_direct[0] && src_sel == SRC_EXT
		|=> group_one_driver.lvl == {DRV_PER_GRP{$past(r_ff.sync2[PIN_EXT])}})
		else $error("group one not fed by external clock");

	route_keep_a: assert property (!grp_pd[0] && grp_direct[0] && src_sel == SRC_NONE
		|=> group_one_driver.lvl == {DRV_PER_GRP{$past(group_one_div_lvl)}})
		else $error("direct bit changed routing with source 01");

	bypass_pass_a: assert property (bypass |=> r_ff.div_out == $past(in_lvl) && !dv_run)
		else $error("bypass did not pass the input");

	force_level_a: assert property (!bypass && ignore_sync
		|=> r_ff.div_out == ($past(force_bit) ? $past(cfg.start_high) : 1'b0))
		else $error("forced level wrong");

	sync_hold_a: assert property ((sync_active && !bypass && !ignore_sync && $stable(cfg.start_high))[*3]
		|-> r_ff.div_out == cfg.start_high && !dv_run)
		else $error("sync did not hold divider at start level");

	low_time_a: assert property ($rose(dv_lvl) && $past(dv_run) && !cfg.dcc_en && !r_ff.hp_dirty
		|-> r_ff.hp_ticks == LEN_W'(cfg.low_cnt) + CYC_ONE)
		else $error("low time wrong");

	high_time_a: assert property ($fell(dv_lvl) && $past(dv_run) && dv_run && !cfg.dcc_en && !r_ff.hp_dirty
		|-> r_ff.hp_ticks == LEN_W'(cfg.high_cnt) + CYC_ONE)
		else $error("high time wrong");

	dcc_low_a: assert property ($rose(dv_lvl) && $past(dv_run) && cfg.dcc_en && !r_ff.hp_dirty
		|-> r_ff.hp_ticks == hp_total - (hp_total >> 1))
		else $error("corrected low time wrong");

	unused_bits_a: assert property (reg_req.rd && reg_req.addr == ADDR_GRP_TWO_CTRL
		|=> reg_rvalid && reg_rdata[DATA_W-1:BIT_PD+1] == '0)
		else $error("unused channel bits read nonzero");

	bypass_c: cover property (bypass && $rose(r_ff.div_out));
	direct_osc_c: cover property (grp_direct[0] && src_sel == SRC_OSC && $rose(group_one_driver.lvl[0]));
	sync_release_c: cover property ($fell(sync_active) ##[1:64] $rose(dv_run));
	dcc_period_c: cover property (cfg.dcc_en && $rose(dv_lvl) && $past(dv_run));
endmodule

// ===== rtl/gocd_pkg.sv
// gocd_pkg: register map, field layout, states and carriers of the grouped output divider
// assumes: byte-wide register port from the serial control core, everything on ref_clk
package gocd_pkg;
	localparam int ADDR_W      = 10;
	localparam int DATA_W      = 8;
	localparam int CNT_W       = 4;
	localparam int LEN_W       = 6;
	localparam int NUM_GROUPS  = 2;
	localparam int DRV_PER_GRP = 3;

	// register offsets, byte addressed as printed
	localparam logic [ADDR_W-1:0] ADDR_GRP_ONE_CTRL = 10'h0195;
	localparam logic [ADDR_W-1:0] ADDR_DIV_COUNTS   = 10'h0196;
	localparam logic [ADDR_W-1:0] ADDR_DIV_CTRL     = 10'h0197;
	localparam logic [ADDR_W-1:0] ADDR_GRP_TWO_CTRL = 10'h0198;
	localparam logic [ADDR_W-1:0] ADDR_STATUS       = 10'h01F0;

	// reset values and implemented bits
	localparam logic [DATA_W-1:0] RST_DIV_COUNTS = 8'h11;
	localparam logic [DATA_W-1:0] RST_DIV_CTRL   = 8'h00;
	localparam logic [DATA_W-1:0] RST_CHAN_CTRL  = 8'h00;
	localparam logic [DATA_W-1:0] CHAN_USED_MASK = 8'h07;

	// field positions
	localparam int LOW_LSB        = 4;
	localparam int HIGH_LSB       = 0;
	localparam int PHASE_LSB      = 0;
	localparam int BIT_BYPASS     = 7;
	localparam int BIT_IGN_SYNC   = 6;
	localparam int BIT_FORCE      = 5;
	localparam int BIT_START_HIGH = 4;
	localparam int BIT_PD         = 2;
	localparam int BIT_DIRECT     = 1;
	localparam int BIT_DCC_DIS    = 0;
	localparam int ST_DIV_OUT     = 0;
	localparam int ST_RUN         = 1;
	localparam int ST_SYNC        = 2;

	// pin synchroniser lanes
	localparam int PIN_OSC = 0;
	localparam int PIN_EXT = 1;
	localparam int PIN_SYNC = 2;
	localparam int PIN_NUM = 3;

	// source-select codes of the external field
	localparam logic [1:0] SRC_EXT  = 2'h0;
	localparam logic [1:0] SRC_NONE = 2'h1;
	localparam logic [1:0] SRC_OSC  = 2'h2;

	localparam logic [LEN_W-1:0] CYC_ONE = 6'h01;

	typedef enum logic [2:0] {
		DIV_HOLD = 3'b001,
		DIV_LOW  = 3'b010,
		DIV_HIGH = 3'b100
	} gocd_div_state_e;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} gocd_reg_req_s;

	typedef struct packed {
		logic [DRV_PER_GRP-1:0] lvl;
		logic                   en;
	} gocd_drv_s;

	typedef struct packed {
		logic             start_high;
		logic [CNT_W-1:0] phase;
		logic [CNT_W-1:0] low_cnt;
		logic [CNT_W-1:0] high_cnt;
		logic             dcc_en;
	} gocd_div_cfg_s;
endpackage

// ===== rtl/gocd_divider.sv
// gocd_divider: low/high cycle counter with phase hold and duty-cycle correction
// assumes: tick is a one-cycle pulse per divider input cycle, same clock
module gocd_divider (
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              tick,
	input  wire logic              restart,
	input  gocd_pkg::gocd_div_cfg_s cfg,
	output logic                   out_lvl,
	output logic                   running
);
	import gocd_pkg::*;

	typedef struct packed {
		gocd_div_state_e  st;
		logic [CNT_W-1:0] cnt;
		logic             lvl;
	} gocd_div_reg_s;

	gocd_div_reg_s    state_ff;
	gocd_div_reg_s    nxt_state;
	logic [LEN_W-1:0] total;
	logic [LEN_W-1:0] hi_len;
	logic [LEN_W-1:0] lo_len;

	// lengths in input cycles; correction halves the whole period, low taking any odd cycle
	always_comb begin
		total = LEN_W'(cfg.low_cnt) + LEN_W'(cfg.high_cnt) + CYC_ONE + CYC_ONE;
		if (cfg.dcc_en) begin
			hi_len = total >> 1;
			lo_len = total - (total >> 1);
		end else begin
			lo_len = LEN_W'(cfg.low_cnt) + CYC_ONE;
			hi_len = LEN_W'(cfg.high_cnt) + CYC_ONE;
		end
		nxt_state = state_ff;
		if (restart) begin
			nxt_state.st  = DIV_HOLD;
			nxt_state.cnt = cfg.phase;
		end else if (tick) begin
			case (state_ff.st)
				DIV_HOLD: begin
					if (state_ff.cnt == '0) begin
						nxt_state.st  = cfg.start_high ? DIV_HIGH : DIV_LOW;
						nxt_state.cnt = cfg.start_high ? CNT_W'(hi_len - CYC_ONE) : CNT_W'(lo_len - CYC_ONE);
					end else begin
						nxt_state.cnt = state_ff.cnt - 1'b1;
					end
				end
				DIV_LOW: begin
					if (state_ff.cnt == '0) begin
						nxt_state.st  = DIV_HIGH;
						nxt_state.cnt = CNT_W'(hi_len - CYC_ONE);
					end else begin
						nxt_state.cnt = state_ff.cnt - 1'b1;
					end
				end
				DIV_HIGH: begin
					if (state_ff.cnt == '0) begin
						nxt_state.st  = DIV_LOW;
						nxt_state.cnt = CNT_W'(lo_len - CYC_ONE);
					end else begin
						nxt_state.cnt = state_ff.cnt - 1'b1;
					end
				end
				default: begin
					nxt_state.st  = DIV_HOLD;
					nxt_state.cnt = cfg.phase;
				end
			endcase
		end
		// while held the output rests at the chosen starting level
		nxt_state.lvl = (nxt_state.st == DIV_HIGH) || ((nxt_state.st == DIV_HOLD) && cfg.start_high);
	end

	// single state register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= '{st: DIV_HOLD, cnt: '0, lvl: 1'b0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign out_lvl = state_ff.lvl;
	assign running = (state_ff.st != DIV_HOLD);
endmodule

// ===== rtl/gocd_route.sv
// gocd_route: picks divider, oscillator or external clock for one group of three drivers
// assumes: all levels already on ref_clk; power-down parks drivers low with enable off
module gocd_route (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       div_lvl,
	input  wire logic       osc_lvl,
	input  wire logic       ext_lvl,
	input  wire logic [1:0] src_sel,
	input  wire logic       direct,
	input  wire logic       pd,
	output gocd_pkg::gocd_drv_s drv
);
	import gocd_pkg::*;

	gocd_drv_s drv_ff;
	gocd_drv_s nxt_drv;
	logic      src_lvl;

	// source choice, then the power-down gate
	always_comb begin
		src_lvl = div_lvl;
		if (direct) begin
			case (src_sel)
				SRC_OSC: src_lvl = osc_lvl;
				SRC_EXT: src_lvl = ext_lvl;
				default: src_lvl = div_lvl;
			endcase
		end
		nxt_drv.lvl = pd ? '0 : {DRV_PER_GRP{src_lvl}};
		nxt_drv.en  = !pd;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			drv_ff <= '{lvl: '0, en: 1'b0};
		end else begin
			drv_ff <= nxt_drv;
		end
	end

	assign drv = drv_ff;
endmodule

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the grouped output divider, register port and group routing
// assumes: gocd_top on a 25 MHz ref_clk; the bench plays clock pins, sync pin and register master
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import gocd_pkg::*;
	logic          ref_clk;
	logic          rstn;
	gocd_reg_req_s reg_req;
	logic [7:0]    reg_rdata;
	logic          reg_rvalid;
	logic [1:0]    src_sel;
	logic          osc_clk_pin;
	logic          ext_clk_pin;
	logic          sync_n_pin;
	logic          group_one_div_lvl;
	gocd_drv_s     group_one_driver;
	gocd_drv_s     group_two_driver;
	logic [1:0]    cnt;
	logic          osc_run;
	int            errors;
	int            num_checks;
	int            cycles;
	int            hi;
	int            lo;
	int            d0;
	int            d1;

	gocd_top dut (
		.ref_clk          (ref_clk),
		.rstn             (rstn),
		.reg_req          (reg_req),
		.reg_rdata        (reg_rdata),
		.reg_rvalid       (reg_rvalid),
		.src_sel          (src_sel),
		.osc_clk_pin      (osc_clk_pin),
		.ext_clk_pin      (ext_clk_pin),
		.sync_n_pin       (sync_n_pin),
		.group_one_div_lvl(group_one_div_lvl),
		.group_one_driver (group_one_driver),
		.group_two_driver (group_two_driver)
	);

	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;

	// oscillator of four ref_clk cycles, one divider tick each; stops when a scenario drives it itself
	always @(posedge ref_clk) begin
		cnt <= cnt + 2'd1;
		if (osc_run) begin
			osc_clk_pin <= cnt[1];
		end
	end

	// hang guard: far above the under one thousand cycles the scenarios need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	// step past an edge so registered outputs have settled before sampling
	task automatic tick_(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_req.wr    <= 1'b1;
		reg_req.addr  <= a;
		reg_req.wdata <= d;
		@(posedge ref_clk);
		reg_req.wr <= 1'b0;
	endtask

	// answer arrives on the edge that takes the read strobe, one cycle after it is raised
	task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_req.rd   <= 1'b1;
		reg_req.addr <= a;
		@(posedge ref_clk);
		reg_req.rd <= 1'b0;
		#1;
		chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
		chk("rdata", reg_rdata, exp);
	endtask

	// samples group two level several times across a span longer than any divider period here
	task automatic hold_chk(input logic [2:0] exp);
		repeat (8) begin
			tick_(5);
			chk("g2_lvl", {5'h00, group_two_driver.lvl}, {5'h00, exp});
		end
	endtask

	// one whole high run and low run, in ref_clk cycles, skipping the partial run in progress
	task automatic measure(output int h, output int l);
		int k;
		k = 0;
		while (group_two_driver.lvl[0] === 1'b1 && k < 200) begin tick_(1); k++; end
		while (group_two_driver.lvl[0] !== 1'b1 && k < 400) begin tick_(1); k++; end
		h = 0;
		while (group_two_driver.lvl[0] === 1'b1 && h < 200) begin tick_(1); h++; end
		l = 0;
		while (group_two_driver.lvl[0] !== 1'b1 && l < 200) begin tick_(1); l++; end
	endtask

	task automatic t_regs();
		rdchk(ADDR_GRP_ONE_CTRL, 8'h00);
		rdchk(ADDR_DIV_COUNTS, 8'h11);
		rdchk(ADDR_DIV_CTRL, 8'h00);
		rdchk(ADDR_GRP_TWO_CTRL, 8'h00);
		rdchk(10'h0100, 8'h00);
		wr(ADDR_GRP_TWO_CTRL, 8'hFF);
		rdchk(ADDR_GRP_TWO_CTRL, 8'h07);
		wr(ADDR_GRP_TWO_CTRL, 8'h00);
		wr(ADDR_STATUS, 8'hFF);
		measure(hi, lo);
		chk("def_high", 8'(hi), 8'd8);
		chk("def_low", 8'(lo), 8'd8);
	endtask

	// each case drives its expected source to v and the two others to the inverse
	task automatic t_route();
		logic [1:0] srcs [4] = '{2'b10, 2'b10, 2'b00, 2'b01};
		int         pick [4] = '{0, 1, 2, 0};
		osc_run = 1'b0;
		for (int i = 0; i < 4; i++) begin
			src_sel <= srcs[i];
			wr(ADDR_GRP_ONE_CTRL, (i == 0) ? 8'h00 : 8'h02);
			for (int v = 0; v < 2; v++) begin
				group_one_div_lvl <= (pick[i] == 0) ? v[0] : ~v[0];
				osc_clk_pin       <= (pick[i] == 1) ? v[0] : ~v[0];
				ext_clk_pin       <= (pick[i] == 2) ? v[0] : ~v[0];
				tick_(6);
				chk("g1_lvl", {5'h00, group_one_driver.lvl}, v[0] ? 8'h07 : 8'h00);
			end
		end
		wr(ADDR_GRP_ONE_CTRL, 8'h04);
		tick_(3);
		chk("g1_pd", {4'h0, group_one_driver.en, group_one_driver.lvl}, 8'h00);
		wr(ADDR_GRP_ONE_CTRL, 8'h00);
		tick_(3);
		chk("g1_en", {7'h00, group_one_driver.en}, 8'h01);
		src_sel <= 2'b10;
		osc_run = 1'b1;
	endtask

	// low 3 high 0: four ticks low and one high without correction, three low and two high with it
	task automatic t_period();
		wr(ADDR_GRP_TWO_CTRL, 8'h01);
		wr(ADDR_DIV_COUNTS, 8'h30);
		tick_(40);
		measure(hi, lo);
		chk("raw_high", 8'(hi), 8'd4);
		chk("raw_low", 8'(lo), 8'd16);
		wr(ADDR_GRP_TWO_CTRL, 8'h00);
		tick_(40);
		measure(hi, lo);
		chk("dcc_high", 8'(hi), 8'd8);
		chk("dcc_low", 8'(lo), 8'd12);
		wr(ADDR_DIV_COUNTS, 8'h11);
	endtask

	task automatic t_bypass();
		osc_run = 1'b0;
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_DIV_CTRL, (i == 0) ? 8'h80 : 8'hF0);
			for (int v = 0; v < 2; v++) begin
				osc_clk_pin <= v[0];
				tick_(6);
				chk("bypass", {5'h00, group_two_driver.lvl}, v[0] ? 8'h07 : 8'h00);
			end
		end
		wr(ADDR_DIV_CTRL, 8'h00);
		osc_run = 1'b1;
	endtask

	// ignore-sync goes in before the force bit is relied on
	task automatic t_force();
		wr(ADDR_DIV_CTRL, 8'h40);
		wr(ADDR_DIV_CTRL, 8'h60);
		hold_chk(3'b000);
		wr(ADDR_DIV_CTRL, 8'h70);
		hold_chk(3'b111);
		rdchk(ADDR_STATUS, 8'h01);
		wr(ADDR_DIV_CTRL, 8'h50);
		hold_chk(3'b000);
		wr(ADDR_DIV_CTRL, 8'h00);
	endtask

	// release sync at a fixed oscillator phase so both delays share the same tick alignment
	task automatic sync_delay(input logic [7:0] ctrl, output int d);
		wr(ADDR_DIV_CTRL, ctrl);
		sync_n_pin <= 1'b0;
		hold_chk(3'b000);
		do tick_(1); while (cnt !== 2'd3);
		@(posedge ref_clk);
		sync_n_pin <= 1'b1;
		d = 0;
		do begin tick_(1); d++; end while (group_two_driver.lvl[0] !== 1'b1 && d < 300);
	endtask

	task automatic t_sync();
		wr(ADDR_DIV_CTRL, 8'h10);
		sync_n_pin <= 1'b0;
		hold_chk(3'b111);
		wr(ADDR_DIV_CTRL, 8'h50);
		hold_chk(3'b000);
		sync_delay(8'h00, d0);
		sync_delay(8'h03, d1);
		chk("phase", 8'(d1 - d0), 8'd12);
		wr(ADDR_DIV_CTRL, 8'h00);
	endtask

	task automatic t_pd_two();
		wr(ADDR_GRP_TWO_CTRL, 8'h04);
		tick_(3);
		chk("g2_pd", {4'h0, group_two_driver.en, group_two_driver.lvl}, 8'h00);
		wr(ADDR_GRP_TWO_CTRL, 8'h00);
		tick_(3);
		chk("g2_en", {7'h00, group_two_driver.en}, 8'h01);
	endtask

	// everything valued at time zero; reset held ten cycles
	initial begin
		errors = 0;
		num_checks = 0;
		cycles = 0;
		cnt = 2'd0;
		osc_run = 1'b1;
		rstn = 1'b0;
		reg_req = '0;
		src_sel = 2'b10;
		osc_clk_pin = 1'b0;
		ext_clk_pin = 1'b0;
		sync_n_pin = 1'b1;
		group_one_div_lvl = 1'b0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		tick_(4);
		t_regs();
		t_route();
		t_period();
		t_bypass();
		t_force();
		t_sync();
		t_pd_two();
		complete_run();
	end
endmodule
